/* brk_pkg.sv */
// Shared constants for the address breakpoint unit and its CPU-side end
`default_nettype none
package brk_pkg;
   // Break unit register indices on the link
   localparam logic [2:0]  IDX_CTRL     = 3'h0;
   localparam logic [2:0]  IDX_ADDR_HI  = 3'h1;
   localparam logic [2:0]  IDX_ADDR_LO  = 3'h2;
   localparam logic [2:0]  IDX_WAIT     = 3'h3;
   localparam logic [2:0]  IDX_FLAGCLR  = 3'h4;
   localparam logic [2:0]  IDX_AUX      = 3'h5;
   // Field positions
   localparam int          ENA_BIT      = 7;
   localparam int          ACT_BIT      = 6;
   localparam int          WFL_BIT      = 1;
   localparam int          FCE_BIT      = 7;
   localparam int          WDS_BIT      = 0;
   // Reset values
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_ADDR     = 16'h0000;
   // Break vectors, user and monitor page
   localparam logic [15:0] VEC_USER     = 16'hFFFC;
   localparam logic [15:0] VEC_MON      = 16'hFEFC;
   // AXI byte offsets of the CPU-side end
   localparam logic [7:0]  AXI_LINK_END = 8'h18;
   localparam logic [7:0]  AXI_IRQ_STAT = 8'h20;
   localparam logic [7:0]  AXI_IRQ_CLR  = 8'h24;
   localparam logic [7:0]  AXI_IRQ_EN   = 8'h28;
   localparam int          EV_TAKEN     = 0;
   localparam int          EV_ENDED     = 1;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : brk_pkg
`default_nettype wire

/* brk_link_if.sv */
// Link between the CPU-side end and the address breakpoint unit
`default_nettype none
interface brk_link_if;
   logic [15:0] prog_addr;
   logic        prog_valid;
   logic        break_ack;
   logic        ret_done;
   logic        cpu_wait;
   logic        cpu_stop;
   logic        reg_wr;
   logic        reg_rd;
   logic [2:0]  reg_idx;
   logic [7:0]  reg_wdata;
   logic        break_req;
   logic        wake;
   logic [7:0]  reg_rdata;

   modport dev (
      input  prog_addr, prog_valid, break_ack, ret_done, cpu_wait, cpu_stop,
      input  reg_wr, reg_rd, reg_idx, reg_wdata,
      output break_req, wake, reg_rdata
   );
   modport cpu (
      output prog_addr, prog_valid, break_ack, ret_done, cpu_wait, cpu_stop,
      output reg_wr, reg_rd, reg_idx, reg_wdata,
      input  break_req, wake, reg_rdata
   );
endinterface : brk_link_if
`default_nettype wire

/* break_unit.sv */
// Address breakpoint unit, device end of the break link
`default_nettype none

module break_unit (
   // Clock and reset
   input  wire logic  ref_clk,
   input  wire logic  rst_n,
   // Link to the CPU-side end
   brk_link_if.dev    link,
   // To timer, watchdog and status flag owners
   output var  logic  timer_stop,
   output var  logic  watchdog_off,
   output var  logic  flag_clear_ok
);
   import brk_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   logic        ena_ff;
   logic        act_ff;
   logic [7:0]  addr_hi_ff;
   logic [7:0]  addr_lo_ff;
   logic        wfl_ff;
   logic        fce_ff;
   logic        wds_ff;
   logic        req_ff;
   logic        in_break_ff;
   logic        nxt_in_break;
   logic        hit;
   logic        sw_brk;
   logic        took;
   logic        low_power;

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic wr_to(input logic       wr,
                                  input logic [2:0] idx,
                                  input logic [2:0] target);
      wr_to = wr && (idx == target);
   endfunction : wr_to

   function automatic logic addr_match(input logic [15:0] pc,
                                       input logic [7:0]  hi,
                                       input logic [7:0]  lo);
      addr_match = (pc == {hi, lo});
   endfunction : addr_match

   // Matches are ignored inside the break routine so it cannot re-enter itself;
   // the accept cycle counts as inside, else a still-matching address re-arms
   always_comb begin
      hit = ena_ff && link.prog_valid && !in_break_ff && !link.break_ack
            && addr_match(link.prog_addr, addr_hi_ff, addr_lo_ff);
   end

   always_comb begin
      sw_brk = wr_to(link.reg_wr, link.reg_idx, IDX_CTRL)
               && link.reg_wdata[ACT_BIT];
   end

   always_comb begin
      took      = link.break_ack && req_ff;
      low_power = link.cpu_wait || link.cpu_stop;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and address registers

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ena_ff <= 1'b0;
      end else if (wr_to(link.reg_wr, link.reg_idx, IDX_CTRL)) begin
         ena_ff <= link.reg_wdata[ENA_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         addr_hi_ff <= RST_ADDR[15:8];
         addr_lo_ff <= RST_ADDR[7:0];
      end else begin
         if (wr_to(link.reg_wr, link.reg_idx, IDX_ADDR_HI)) begin
            addr_hi_ff <= link.reg_wdata;
         end
         if (wr_to(link.reg_wr, link.reg_idx, IDX_ADDR_LO)) begin
            addr_lo_ff <= link.reg_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fce_ff <= RST_BYTE[FCE_BIT];
         wds_ff <= RST_BYTE[WDS_BIT];
      end else begin
         if (wr_to(link.reg_wr, link.reg_idx, IDX_FLAGCLR)) begin
            fce_ff <= link.reg_wdata[FCE_BIT];
         end
         if (wr_to(link.reg_wr, link.reg_idx, IDX_AUX)) begin
            wds_ff <= link.reg_wdata[WDS_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags; a set in the same cycle as a clear wins

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         act_ff <= 1'b0;
      end else if (hit || sw_brk) begin
         act_ff <= 1'b1;
      end else if (wr_to(link.reg_wr, link.reg_idx, IDX_CTRL)) begin
         act_ff <= 1'b0;
      end
   end

   // Only a write of zero clears; a one written here is ignored
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wfl_ff <= 1'b0;
      end else if (took && low_power) begin
         wfl_ff <= 1'b1;
      end else if (wr_to(link.reg_wr, link.reg_idx, IDX_WAIT)
                   && !link.reg_wdata[WFL_BIT]) begin
         wfl_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Break request and break state

   // Held so a match in mid-instruction survives to the next boundary
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         req_ff <= 1'b0;
      end else if (hit || sw_brk) begin
         req_ff <= 1'b1;
      end else if (took) begin
         req_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         link.break_req <= 1'b0;
      end else begin
         link.break_req <= (req_ff && !took) || hit || sw_brk;
      end
   end

   always_comb begin
      nxt_in_break = in_break_ff;
      if (took) begin
         nxt_in_break = 1'b1;
      end else if (link.ret_done) begin
         nxt_in_break = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         in_break_ff <= 1'b0;
      end else begin
         in_break_ff <= nxt_in_break;
      end
   end

   // Pending break pulls the core out of wait or stop
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         link.wake <= 1'b0;
      end else begin
         link.wake <= (req_ff || hit || sw_brk) && low_power;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs to timer, watchdog and flag owners

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         timer_stop <= 1'b0;
      end else begin
         timer_stop <= nxt_in_break;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         watchdog_off <= 1'b0;
      end else begin
         watchdog_off <= nxt_in_break && wds_ff;
      end
   end

   // Outside a break, flags always clear normally
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flag_clear_ok <= 1'b1;
      end else begin
         flag_clear_ok <= !nxt_in_break || fce_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the read strobe

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         link.reg_rdata <= RST_BYTE;
      end else if (link.reg_rd) begin
         case (link.reg_idx)
            IDX_CTRL:    link.reg_rdata <= {ena_ff, act_ff, 6'h00};
            IDX_ADDR_HI: link.reg_rdata <= addr_hi_ff;
            IDX_ADDR_LO: link.reg_rdata <= addr_lo_ff;
            IDX_WAIT:    link.reg_rdata <= {6'h00, wfl_ff, 1'b0};
            IDX_FLAGCLR: link.reg_rdata <= {fce_ff, 7'h00};
            IDX_AUX:     link.reg_rdata <= {7'h00, wds_ff};
            default:     link.reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule : break_unit
`default_nettype wire

/* cpu_break_end.sv */
// CPU-side end of the break link, with AXI4-Lite register access
`default_nettype none

module cpu_break_end (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Link to the breakpoint unit
   brk_link_if.cpu          link,
   // Core side
   input  wire logic [15:0] core_addr,
   input  wire logic        core_addr_prog,
   input  wire logic        core_boundary,
   input  wire logic        core_ret,
   input  wire logic        core_wait,
   input  wire logic        core_stop,
   input  wire logic        monitor_mode,
   output var  logic        take_trap,
   output var  logic [15:0] trap_vector,
   output var  logic        wake_core,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupt
   output var  logic        irq
);
   import brk_pkg::*;

   typedef enum {RD_IDLE, RD_LINK1, RD_LINK2} rd_state_t;

   logic        in_brk_ff;
   logic        ev_take;
   logic        ev_end;
   logic [1:0]  irq_stat_ff;
   logic [1:0]  irq_en_ff;
   logic [1:0]  nxt_stat;
   logic        wr_go;
   logic        rd_go;
   rd_state_t   rd_state_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Break entry and exit

   always_comb begin
      ev_take = core_boundary && link.break_req && !in_brk_ff;
      ev_end  = core_ret && in_brk_ff;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         in_brk_ff       <= 1'b0;
         take_trap       <= 1'b0;
         trap_vector     <= VEC_USER;
         link.break_ack  <= 1'b0;
         link.ret_done   <= 1'b0;
      end else begin
         take_trap      <= ev_take;
         link.break_ack <= ev_take;
         link.ret_done  <= ev_end;
         if (ev_take) begin
            in_brk_ff   <= 1'b1;
            trap_vector <= monitor_mode ? VEC_MON : VEC_USER;
         end else if (ev_end) begin
            in_brk_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         link.prog_addr  <= RST_ADDR;
         link.prog_valid <= 1'b0;
         link.cpu_wait   <= 1'b0;
         link.cpu_stop   <= 1'b0;
         wake_core       <= 1'b0;
      end else begin
         link.prog_addr  <= core_addr;
         link.prog_valid <= core_addr_prog;
         link.cpu_wait   <= core_wait;
         link.cpu_stop   <= core_stop;
         wake_core       <= link.wake;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, clear and enable; set wins over clear

   always_comb begin
      nxt_stat = irq_stat_ff;
      if (wr_go && s_axi_awaddr == AXI_IRQ_CLR) begin
         nxt_stat = irq_stat_ff & ~s_axi_wdata[1:0];
      end
      if (ev_take) begin
         nxt_stat[EV_TAKEN] = 1'b1;
      end
      if (ev_end) begin
         nxt_stat[EV_ENDED] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_stat_ff <= 2'h0;
         irq_en_ff   <= 2'h0;
         irq         <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_stat;
         if (wr_go && s_axi_awaddr == AXI_IRQ_EN) begin
            irq_en_ff <= s_axi_wdata[1:0];
         end
         irq <= |(nxt_stat & irq_en_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI write: both channels taken in one edge, then response

   always_comb begin
      wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
      rd_go = s_axi_arvalid && s_axi_arready;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_awready  <= 1'b0;
         s_axi_wready   <= 1'b0;
         s_axi_bvalid   <= 1'b0;
         s_axi_bresp    <= RESP_OKAY;
         link.reg_wr    <= 1'b0;
         link.reg_wdata <= RST_BYTE;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                          && !s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                          && !s_axi_bvalid;
         link.reg_wr   <= wr_go && s_axi_awaddr < AXI_LINK_END && s_axi_wstrb[0];
         if (wr_go) begin
            link.reg_wdata <= s_axi_wdata[7:0];
            s_axi_bvalid   <= 1'b1;
            s_axi_bresp    <= (s_axi_awaddr < AXI_LINK_END || s_axi_awaddr == AXI_IRQ_CLR
                               || s_axi_awaddr == AXI_IRQ_EN) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI read; link reads take two extra cycles for the unit's read flop

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_state_ff   <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
         link.reg_rd   <= 1'b0;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
                          && rd_state_ff == RD_IDLE;
         link.reg_rd   <= rd_go && s_axi_araddr < AXI_LINK_END;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         case (rd_state_ff)
            RD_IDLE: begin
               if (rd_go && s_axi_araddr < AXI_LINK_END) begin
                  rd_state_ff <= RD_LINK1;
               end else if (rd_go) begin
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp  <= RESP_OKAY;
                  case (s_axi_araddr)
                     AXI_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_ff};
                     AXI_IRQ_EN:   s_axi_rdata <= {30'h0, irq_en_ff};
                     default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                     end
                  endcase
               end
            end
            RD_LINK1: rd_state_ff <= RD_LINK2;
            RD_LINK2: begin
               s_axi_rdata  <= {24'h000000, link.reg_rdata};
               s_axi_rresp  <= RESP_OKAY;
               s_axi_rvalid <= 1'b1;
               rd_state_ff  <= RD_IDLE;
            end
            default: rd_state_ff <= RD_IDLE;
         endcase
      end
   end

   // Link register index follows whichever channel was taken last; a write wins over a read taken in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         link.reg_idx <= IDX_CTRL;
      end else if (wr_go) begin
         link.reg_idx <= s_axi_awaddr[4:2];
      end else if (rd_go) begin
         link.reg_idx <= s_axi_araddr[4:2];
      end
   end

endmodule : cpu_break_end
`default_nettype wire

/* break_link_props.sv */
// Checker for the break link between the two design ends
`default_nettype none
module break_link_props (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // Link signals
   input wire logic [15:0] prog_addr,
   input wire logic        prog_valid,
   input wire logic        break_ack,
   input wire logic        ret_done,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [2:0]  reg_idx,
   input wire logic [7:0]  reg_wdata,
   input wire logic        break_req,
   input wire logic [7:0]  reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import brk_pkg::*;
   logic        en_ff;
   logic        brk_ff;
   logic        frc_ff;
   logic [15:0] bp_ff;
   logic        hit;
   logic        frc;
   assign frc = reg_wr && reg_idx == IDX_CTRL && reg_wdata[ACT_BIT];
   // Pending request absorbs a repeat match
   assign hit = prog_valid && en_ff && !brk_ff && !break_req && prog_addr == bp_ff;
   ////////////////////////////////////////
   // Shadow of what the unit was told
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         en_ff  <= 1'b0;
         bp_ff  <= RST_ADDR;
         frc_ff <= 1'b0;
      end else begin
         frc_ff <= frc;
         if (reg_wr && reg_idx == IDX_CTRL) en_ff <= reg_wdata[ENA_BIT];
         if (reg_wr && reg_idx == IDX_ADDR_HI) bp_ff[15:8] <= reg_wdata;
         if (reg_wr && reg_idx == IDX_ADDR_LO) bp_ff[7:0] <= reg_wdata;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) brk_ff <= 1'b0;
      else if (break_ack) brk_ff <= 1'b1;
      else if (ret_done) brk_ff <= 1'b0;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_match; hit |=> break_req; endproperty
   a_match: assert property (p_match) else $error("no request on match");
   property p_quiet; !break_req && !hit && !frc && !frc_ff |=> !break_req; endproperty
   a_quiet: assert property (p_quiet) else $error("request without cause");
   property p_force; frc && !break_req && !brk_ff |-> ##[1:2] break_req; endproperty
   a_force: assert property (p_force) else $error("forced break lost");
   property p_hold; break_req && !break_ack |=> break_req; endproperty
   a_hold: assert property (p_hold) else $error("request dropped early");
   property p_drop; break_ack |=> !break_req; endproperty
   a_drop: assert property (p_drop) else $error("request after ack");
   property p_ack; break_ack |-> break_req; endproperty
   a_ack: assert property (p_ack) else $error("ack without request");
   property p_rd_en; reg_rd && reg_idx == IDX_CTRL |=> reg_rdata[ENA_BIT] == en_ff; endproperty
   a_rd_en: assert property (p_rd_en) else $error("enable bit read wrong");
   property p_rd_hi; reg_rd && reg_idx == IDX_ADDR_HI |=> reg_rdata == bp_ff[15:8]; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("high byte read wrong");
   property p_rd_lo; reg_rd && reg_idx == IDX_ADDR_LO |=> reg_rdata == bp_ff[7:0]; endproperty
   a_rd_lo: assert property (p_rd_lo) else $error("low byte read wrong");
endmodule : break_link_props
`default_nettype wire

/* address_breakpoint_unit_tb_top.sv */
// Testbench joining the break unit to its CPU-side end
`default_nettype none
module address_breakpoint_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import brk_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] core_addr = 16'h0000;
   logic        addr_prog = 1'b0, boundary = 1'b0, ret = 1'b0;
   logic        cwait = 1'b0, cstop = 1'b0, mon = 1'b0;
   logic        take_trap, wake_core, irq, timer_stop, watchdog_off, flag_clear_ok;
   logic [15:0] trap_vector;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   int          fail_count = 0;
   int          tests_run = 0;
   brk_link_if u_link ();
   break_unit u_break_unit (.ref_clk(ref_clk), .rst_n(rst_n), .link(u_link.dev),
      .timer_stop(timer_stop), .watchdog_off(watchdog_off), .flag_clear_ok(flag_clear_ok));
   cpu_break_end u_cpu_break_end (.ref_clk(ref_clk), .rst_n(rst_n), .link(u_link.cpu),
      .core_addr(core_addr), .core_addr_prog(addr_prog), .core_boundary(boundary),
      .core_ret(ret), .core_wait(cwait), .core_stop(cstop), .monitor_mode(mon),
      .take_trap(take_trap), .trap_vector(trap_vector), .wake_core(wake_core), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   break_link_props u_break_link_props (.ref_clk(ref_clk), .rst_n(rst_n),
      .prog_addr(u_link.prog_addr), .prog_valid(u_link.prog_valid),
      .break_ack(u_link.break_ack), .ret_done(u_link.ret_done), .reg_wr(u_link.reg_wr),
      .reg_rd(u_link.reg_rd), .reg_idx(u_link.reg_idx), .reg_wdata(u_link.reg_wdata),
      .break_req(u_link.break_req), .reg_rdata(u_link.reg_rdata));
   always #2.5 ref_clk = ~ref_clk;
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_flag(input logic got, input logic exp, input string what);
      chk({31'h0, got}, {31'h0, exp}, what);
   endtask : chk_flag
   // Handshakes judged on what stands just before the edge that samples them
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic       aw_go;
      logic       w_go;
      logic       b_go;
      logic [1:0] got;
      b_go = 1'b0;
      @(posedge ref_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_go) begin
         #1;
         aw_go = awvalid && awready === 1'b1;
         w_go = wvalid && wready === 1'b1;
         b_go = bvalid === 1'b1;
         got = bresp;
         @(posedge ref_clk);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk({30'h0, got}, {30'h0, er}, "write resp");
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic        ar_go;
      logic        r_go;
      logic [31:0] got;
      logic [1:0]  got_resp;
      r_go = 1'b0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_go) begin
         #1;
         ar_go = arvalid && arready === 1'b1;
         r_go = rvalid === 1'b1;
         got = rdata;
         got_resp = rresp;
         @(posedge ref_clk);
         if (ar_go) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      chk(got, exp, "read data");
      chk({30'h0, got_resp}, {30'h0, er}, "read resp");
   endtask : axi_read
   ////////////////////////////////////////
   task automatic pulse_core(input logic brk);
      @(posedge ref_clk);
      if (brk) boundary <= 1'b1;
      else ret <= 1'b1;
      @(posedge ref_clk);
      boundary <= 1'b0;
      ret <= 1'b0;
   endtask : pulse_core
   task automatic drive_addr(input logic [15:0] a, input logic p);
      @(posedge ref_clk);
      core_addr <= a;
      addr_prog <= p;
      repeat (6) @(posedge ref_clk);
      #1;
      chk_flag(u_link.break_req, 1'b0, "no request");
   endtask : drive_addr
   task automatic take_break(input logic [15:0] vec);
      int n;
      n = 0;
      while (u_link.break_req !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk_flag(u_link.break_req, 1'b1, "request");
      pulse_core(1'b1);
      #1;
      chk_flag(take_trap, 1'b1, "trap");
      chk({16'h0, trap_vector}, {16'h0, vec}, "vector");
      @(posedge ref_clk);
      #1;
      chk_flag(timer_stop, 1'b1, "timer stop");
      chk_flag(u_link.break_req, 1'b0, "request after ack");
   endtask : take_break
   task automatic end_break;
      pulse_core(1'b0);
      repeat (3) @(posedge ref_clk);
      #1;
      chk_flag(timer_stop, 1'b0, "timer after return");
   endtask : end_break
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////
   // Bound well above the few hundred cycles the tests need
   initial begin
      #100000;
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test;
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 24; a += 4) axi_read(8'(a), 32'h0, RESP_OKAY);
      axi_read(8'h30, 32'h0, RESP_SLVERR);
      chk_flag(flag_clear_ok, 1'b1, "clear enable");
      $display("test reset done");
      axi_write(8'h04, 32'hFFFF_FF12, RESP_OKAY);
      axi_write(8'h08, 32'h0000_0034, RESP_OKAY);
      axi_write(8'h14, 32'h0000_0001, RESP_OKAY);
      axi_write(8'h10, 32'h0000_0080, RESP_OKAY);
      axi_write(AXI_IRQ_EN, 32'h0000_0003, RESP_OKAY);
      axi_write(8'h00, 32'h0000_0080, RESP_OKAY);
      axi_read(8'h04, 32'h0000_0012, RESP_OKAY);
      axi_read(8'h08, 32'h0000_0034, RESP_OKAY);
      axi_read(8'h14, 32'h0000_0001, RESP_OKAY);
      drive_addr(16'h1234, 1'b0);
      drive_addr(16'h1236, 1'b1);
      @(posedge ref_clk);
      core_addr <= 16'h1234;
      take_break(VEC_USER);
      @(posedge ref_clk);
      addr_prog <= 1'b0;
      #1;
      chk_flag(watchdog_off, 1'b1, "watchdog off");
      chk_flag(flag_clear_ok, 1'b1, "clear enable");
      chk_flag(irq, 1'b1, "irq taken");
      axi_read(AXI_IRQ_STAT, 32'h1, RESP_OKAY);
      axi_read(8'h00, 32'h0000_00C0, RESP_OKAY);
      axi_write(AXI_IRQ_CLR, 32'h1, RESP_OKAY);
      axi_write(8'h00, 32'h0000_0080, RESP_OKAY);
      axi_read(8'h00, 32'h0000_0080, RESP_OKAY);
      end_break;
      axi_read(AXI_IRQ_STAT, 32'h2, RESP_OKAY);
      axi_write(AXI_IRQ_CLR, 32'h2, RESP_OKAY);
      @(posedge ref_clk);
      #1;
      chk_flag(irq, 1'b0, "irq cleared");
      $display("test address break done");
      axi_write(8'h00, 32'h0, RESP_OKAY);
      drive_addr(16'h1234, 1'b1);
      $display("test disabled done");
      axi_write(8'h14, 32'h0, RESP_OKAY);
      axi_write(8'h10, 32'h0, RESP_OKAY);
      axi_write(AXI_IRQ_EN, 32'h0, RESP_OKAY);
      for (int m = 0; m < 2; m++) begin
         @(posedge ref_clk);
         mon <= 1'b1;
         cwait <= (m == 0);
         cstop <= (m == 1);
         axi_write(8'h00, 32'h0000_0040, RESP_OKAY);
         repeat (4) @(posedge ref_clk);
         #1;
         chk_flag(wake_core, 1'b1, "wake");
         take_break(VEC_MON);
         chk_flag(watchdog_off, 1'b0, "watchdog on");
         chk_flag(flag_clear_ok, 1'b0, "clear blocked");
         chk_flag(irq, 1'b0, "masked irq");
         axi_read(AXI_IRQ_STAT, 32'h1, RESP_OKAY);
         axi_read(8'h0C, 32'h2, RESP_OKAY);
         axi_write(8'h0C, 32'h0, RESP_OKAY);
         axi_read(8'h0C, 32'h0, RESP_OKAY);
         axi_write(8'h00, 32'h0, RESP_OKAY);
         @(posedge ref_clk);
         cwait <= 1'b0;
         cstop <= 1'b0;
         end_break;
         chk_flag(flag_clear_ok, 1'b1, "clear enable");
         axi_write(AXI_IRQ_CLR, 32'h3, RESP_OKAY);
      end
      $display("test forced break done");
      stop_test;
   end
endmodule : address_breakpoint_unit_tb_top
`default_nettype wire
